// >>> smhc_port.sv
/*
 * Host command port of the system monitor: status/command and data ports,
 * command sequencer with data timeout, serial ASCII command parser, settings
 * and watchdog. Assumes a 25 MHz clock; serial and modem pins are asynchronous
 * and pass two flip-flops. The 8-entry reply FIFO is never written, so no bytes are returned.
 */
`timescale 1ns/1ps
`include "smhc_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Status bit 0 is set when no unprocessed command is held.
// - Status bit 1 is set when no unconsumed data byte is held.
// - Status bit 2 is set while a reply byte waits in the data port.
// - Status bit 7 reads one when no interrupt or SMI is queued.
// - Interrupt delivery waits while a command is in progress.
// - A command waiting for data is dropped after two seconds idle.
// - Serial link is 9600 baud, 8 data bits, no parity, one stop.
// - Serial strings start with @, two hex digits per field, colon separated.
// - Fields must be two digits; execution happens only on carriage return.
// - Password, dial string and unit ID commands are refused on serial.
// - Three-byte password; nonzero locks serial until entered, zero disables.
// - After dialling, carrier must appear within two minutes or dialling stops.
// - Unit ID holds up to ten bytes, ended by 2A.
// - Verbose command: zero hex only, one verbose; verbose on after reset.
// - Warning count raises warning alarms when the watchdog count reaches it.
// - Strobe command without data restarts the watchdog counter.
// - Serial transmitter waits for CTS; RTS is held asserted outside reset.
module smhc_port
	import smhc_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic [11:0] I_IO_ADDR,
	input wire logic I_IO_WR,
	input wire logic I_IO_RD,
	input wire logic [7:0] I_IO_WDATA,
	output logic [7:0] O_IO_RDATA,
	input wire logic I_IRQ_REQ,
	output logic O_IRQ_GO,
	input wire logic I_SER_RXD,
	output logic O_SER_TXD,
	input wire logic I_SER_CTS_B,
	output logic O_SER_RTS_B,
	input wire logic I_SER_DCD,
	input wire logic I_ERR_EVENT,
	output logic O_DIAL_ACTIVE,
	output logic O_ECHO_EN,
	output logic O_VERBOSE,
	output logic O_PW_LOCKED,
	output logic O_WD_WARN,
	output logic O_WD_RESET
);
	smhc_cmd_state_t st_q;
	smhc_ser_state_t sp_q;
	logic [7:0] cmd_q;
	logic [4:0] need_q;
	logic [4:0] idx_q;
	logic din_full_q;
	logic [7:0] din_q;
	logic [31:0] tmo_q;
	logic from_ser_q;
	logic [7:0] ser_buf_q [4];
	logic [2:0] ser_n_q;
	logic [7:0] dial_q [`SMHC_DIAL_MAX];
	logic [7:0] unit_q [`SMHC_UNIT_MAX];
	logic [4:0] dial_len_q;
	logic [3:0] unit_len_q;
	logic [7:0] pw_q [`SMHC_PW_LEN];
	logic pw_ok_q;
	logic echo_q;
	logic verbose_q;
	logic [7:0] wd_load_q;
	logic [7:0] wd_warn_q;
	logic [7:0] wd_cnt_q;
	logic [23:0] tick_q;
	logic tick;
	logic [11:0] dcd_q;
	logic dial_act_q;
	logic [7:0] bus_byte;
	logic bus_valid;
	logic exec;
	logic [7:0] out_data;
	logic out_valid;
	logic out_pop;
	logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q, dcd_s1_q, dcd_s2_q;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: first stage feeds only the second
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			{rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q, dcd_s1_q, dcd_s2_q} <= 6'h3c; // Idle levels: no false start bit
		end else begin
			rx_s1_q <= I_SER_RXD;
			rx_s2_q <= rx_s1_q;
			cts_s1_q <= I_SER_CTS_B;
			cts_s2_q <= cts_s1_q;
			dcd_s1_q <= I_SER_DCD;
			dcd_s2_q <= dcd_s1_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Serial receiver, 8N1, samples mid-bit
	logic [15:0] rx_div_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_stb;
	assign rx_stb = (rx_bit_q == 4'h9) && (rx_div_q == 16'h0000);
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rx_div_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
		end else if (rx_bit_q == 4'h0) begin
			if (!rx_s2_q) begin
				rx_bit_q <= 4'h1;
				rx_div_q <= 16'((`SMHC_BIT_CYC * 3) / 2);
			end
		end else if (rx_div_q != 16'h0000) begin
			rx_div_q <= rx_div_q - 16'h0001;
		end else if (rx_bit_q == 4'h9) begin
			rx_bit_q <= 4'h0; // Stop bit; a framing error just drops the byte
		end else begin
			rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
			rx_bit_q <= rx_bit_q + 4'h1;
			rx_div_q <= 16'(`SMHC_BIT_CYC - 1);
		end
	end
	wire rx_good = rx_stb && rx_s2_q;

	// Receiver is always ready, so RTS stays asserted outside reset
	assign O_SER_RTS_B = !I_RST_B;

	//////////////////////////////////////////////////////////////////////////
	// Serial transmitter: echoes received characters, gated by CTS
	logic [15:0] tx_div_q;
	logic [3:0] tx_bit_q;
	logic [9:0] tx_sh_q;
	logic [7:0] echo_ch_q;
	logic echo_pend_q;
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tx_div_q <= 16'h0000;
			tx_bit_q <= 4'h0;
			tx_sh_q <= 10'h3ff;
			echo_pend_q <= 1'b0;
			echo_ch_q <= 8'h00;
		end else begin
			if (rx_good && echo_q) begin
				echo_pend_q <= 1'b1;
				echo_ch_q <= rx_sh_q;
			end
			if (tx_bit_q == 4'h0) begin
				if (echo_pend_q && !cts_s2_q) begin
					tx_sh_q <= {1'b1, echo_ch_q, 1'b0};
					tx_bit_q <= 4'ha;
					tx_div_q <= 16'(`SMHC_BIT_CYC - 1);
					echo_pend_q <= rx_good && echo_q;
				end
			end else if (tx_div_q != 16'h0000) begin
				tx_div_q <= tx_div_q - 16'h0001;
			end else begin
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				tx_bit_q <= tx_bit_q - 4'h1;
				tx_div_q <= 16'(`SMHC_BIT_CYC - 1);
			end
		end
	end
	assign O_SER_TXD = tx_sh_q[0];

	//////////////////////////////////////////////////////////////////////////
	// Serial ASCII parser: @HH:HH...<CR>
	logic [3:0] hex_val;
	logic hex_ok;
	logic [3:0] hi_q;
	logic ser_fire_q;
	always_comb begin
		hex_ok = 1'b1;
		hex_val = 4'h0;
		if (rx_sh_q >= 8'h30 && rx_sh_q <= 8'h39) begin
			hex_val = rx_sh_q[3:0];
		end else if ((rx_sh_q >= 8'h41 && rx_sh_q <= 8'h46) || (rx_sh_q >= 8'h61 && rx_sh_q <= 8'h66)) begin
			hex_val = rx_sh_q[3:0] + 4'h9;
		end else begin
			hex_ok = 1'b0;
		end
	end
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sp_q <= SMHC_SP_WAIT;
			hi_q <= 4'h0;
			ser_n_q <= 3'h0;
			ser_fire_q <= 1'b0;
			for (int k = 0; k < 4; k++) begin
				ser_buf_q[k] <= 8'h00;
			end
		end else begin
			ser_fire_q <= 1'b0;
			if (rx_good) begin
				if (rx_sh_q == `SMHC_CH_AT) begin
					sp_q <= SMHC_SP_HI;
					ser_n_q <= 3'h0;
				end else begin
					case (sp_q)
						SMHC_SP_HI: begin
							sp_q <= hex_ok ? SMHC_SP_LO : SMHC_SP_WAIT;
							hi_q <= hex_val;
						end
						SMHC_SP_LO: begin
							if (hex_ok && ser_n_q != 3'h4) begin
								ser_buf_q[ser_n_q[1:0]] <= {hi_q, hex_val};
								ser_n_q <= ser_n_q + 3'h1;
								sp_q <= SMHC_SP_SEP;
							end else begin
								sp_q <= SMHC_SP_WAIT;
							end
						end
						SMHC_SP_SEP: begin
							if (rx_sh_q == `SMHC_CH_COLON) begin
								sp_q <= SMHC_SP_HI;
							end else begin
								ser_fire_q <= (rx_sh_q == `SMHC_CH_CR);
								sp_q <= SMHC_SP_WAIT;
							end
						end
						default: sp_q <= SMHC_SP_WAIT;
					endcase
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Password lock: serial needs a line of exactly the three password fields
	wire pw_set = (pw_q[0] | pw_q[1] | pw_q[2]) != 8'h00;
	wire pw_match = (ser_n_q == 3'h3) && (ser_buf_q[0] == pw_q[0]) && (ser_buf_q[1] == pw_q[1]) && (ser_buf_q[2] == pw_q[2]);
	wire ser_priv = (ser_buf_q[0] == `SMHC_CMD_PASSWORD) || (ser_buf_q[0] == `SMHC_CMD_DIAL) || (ser_buf_q[0] == `SMHC_CMD_UNITID);
	wire ser_ok = ser_fire_q && (!pw_set || pw_ok_q) && !ser_priv;
	assign O_PW_LOCKED = pw_set && !pw_ok_q;

	//////////////////////////////////////////////////////////////////////////
	// Host port decode; undefined status bits read zero
	wire wr_cmd = I_IO_WR && (I_IO_ADDR == `SMHC_OFF_CMD);
	wire wr_dat = I_IO_WR && (I_IO_ADDR == `SMHC_OFF_DATA);
	wire rd_dat = I_IO_RD && (I_IO_ADDR == `SMHC_OFF_DATA);
	wire ser_busy;
	assign ser_busy = 1'b0;
	wire cbe = (st_q == SMHC_IDLE) && !ser_busy;
	always_comb begin
		O_IO_RDATA = 8'h00;
		if (I_IO_ADDR == `SMHC_OFF_CMD) begin
			O_IO_RDATA[`SMHC_ST_CBE] = cbe;
			O_IO_RDATA[`SMHC_ST_IBE] = !din_full_q;
			O_IO_RDATA[`SMHC_ST_OBF] = out_valid;
			O_IO_RDATA[`SMHC_ST_NIRQ] = !I_IRQ_REQ;
		end else if (I_IO_ADDR == `SMHC_OFF_DATA) begin
			O_IO_RDATA = out_valid ? out_data : 8'h00;
		end
	end
	assign out_pop = rd_dat;
	// Interrupts wait until no command is being handled
	assign O_IRQ_GO = I_IRQ_REQ && cbe;

	//////////////////////////////////////////////////////////////////////////
	// Command sequencer: counts data bytes, times out, executes
	function automatic logic [4:0] data_need(input logic [7:0] c);
		case (c)
			`SMHC_CMD_PASSWORD: data_need = 5'd3;
			`SMHC_CMD_DIAL: data_need = 5'd20;
			`SMHC_CMD_UNITID: data_need = 5'd10;
			`SMHC_CMD_ECHO, `SMHC_CMD_VERBOSE, `SMHC_CMD_WDEN, `SMHC_CMD_WDWARN: data_need = 5'd1;
			default: data_need = 5'd0;
		endcase
	endfunction
	assign bus_valid = din_full_q && (st_q == SMHC_DATA);
	assign bus_byte = din_q;
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			st_q <= SMHC_IDLE;
			cmd_q <= 8'h00;
			need_q <= 5'd0;
			idx_q <= 5'd0;
			din_full_q <= 1'b0;
			din_q <= 8'h00;
			tmo_q <= 32'h0;
		end else begin
			if (wr_dat && !din_full_q) begin
				din_full_q <= 1'b1;
				din_q <= I_IO_WDATA;
			end
			case (st_q)
				SMHC_IDLE: begin
					idx_q <= 5'd0;
					tmo_q <= 32'h0;
					if (wr_cmd) begin
						cmd_q <= I_IO_WDATA;
						need_q <= data_need(I_IO_WDATA);
						st_q <= (data_need(I_IO_WDATA) == 5'd0) ? SMHC_EXEC : SMHC_DATA;
					end
				end
				SMHC_DATA: begin
					tmo_q <= tmo_q + 32'h1;
					if (din_full_q) begin
						din_full_q <= 1'b0;
						tmo_q <= 32'h0;
						idx_q <= idx_q + 5'd1;
						if (idx_q + 5'd1 == need_q || ((cmd_q == `SMHC_CMD_DIAL || cmd_q == `SMHC_CMD_UNITID) && din_q == `SMHC_STR_END)) begin
							st_q <= SMHC_EXEC;
						end
					end else if (tmo_q == 32'(`SMHC_TIMEOUT_CYC - 1)) begin
						st_q <= SMHC_IDLE;
					end
				end
				default: st_q <= SMHC_IDLE;
			endcase
		end
	end
	assign exec = (st_q == SMHC_EXEC) || ser_ok;
	wire [7:0] ex_cmd = ser_ok ? ser_buf_q[0] : cmd_q;
	wire [7:0] ex_arg = ser_ok ? ser_buf_q[1] : din_q;

	//////////////////////////////////////////////////////////////////////////
	// Stored settings and strings
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			echo_q <= `SMHC_RST_ECHO;
			verbose_q <= `SMHC_RST_VERBOSE;
			wd_load_q <= 8'h00;
			wd_warn_q <= 8'h00;
			dial_len_q <= 5'd0;
			unit_len_q <= 4'h0;
			pw_ok_q <= 1'b0;
			for (int k = 0; k < `SMHC_PW_LEN; k++) begin
				pw_q[k] <= 8'h00;
			end
		end else begin
			if (ser_fire_q && pw_set && !pw_ok_q && pw_match) begin
				pw_ok_q <= 1'b1;
			end
			if (bus_valid && din_q != `SMHC_STR_END) begin
				if (cmd_q == `SMHC_CMD_PASSWORD) begin
					pw_q[idx_q[1:0]] <= din_q;
					pw_ok_q <= 1'b0;
				end
				if (cmd_q == `SMHC_CMD_DIAL) begin
					dial_q[idx_q] <= din_q;
					dial_len_q <= idx_q + 5'd1;
				end
				if (cmd_q == `SMHC_CMD_UNITID) begin
					unit_q[idx_q[3:0]] <= din_q;
					unit_len_q <= idx_q[3:0] + 4'h1;
				end
			end
			if (bus_valid && idx_q == 5'd0 && cmd_q == `SMHC_CMD_DIAL) begin
				dial_len_q <= 5'd0;
			end
			if (bus_valid && idx_q == 5'd0 && cmd_q == `SMHC_CMD_UNITID) begin
				unit_len_q <= 4'h0;
			end
			if (exec) begin
				if (ex_cmd == `SMHC_CMD_ECHO) echo_q <= ex_arg[0];
				if (ex_cmd == `SMHC_CMD_VERBOSE) verbose_q <= ex_arg[0];
				if (ex_cmd == `SMHC_CMD_WDEN) wd_load_q <= ex_arg;
				if (ex_cmd == `SMHC_CMD_WDWARN) wd_warn_q <= ex_arg;
			end
		end
	end
	assign O_ECHO_EN = echo_q;
	assign O_VERBOSE = verbose_q;

	//////////////////////////////////////////////////////////////////////////
	// Watchdog on a 50 ms tick
	assign tick = (tick_q == 24'(`SMHC_TICK_CYC - 1));
	wire wd_reload = exec && (ex_cmd == `SMHC_CMD_WDEN || ex_cmd == `SMHC_CMD_STROBE);
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tick_q <= 24'h0;
			wd_cnt_q <= 8'h00;
			O_WD_WARN <= 1'b0;
			O_WD_RESET <= 1'b0;
		end else begin
			tick_q <= tick ? 24'h0 : tick_q + 24'h1;
			O_WD_RESET <= 1'b0;
			if (wd_reload) begin
				wd_cnt_q <= (ex_cmd == `SMHC_CMD_WDEN) ? ex_arg : wd_load_q;
				O_WD_WARN <= 1'b0;
			end else if (tick && wd_load_q != 8'h00 && wd_cnt_q != 8'h00) begin
				wd_cnt_q <= wd_cnt_q - 8'h01;
				if (wd_cnt_q - 8'h01 == wd_warn_q && wd_warn_q != 8'h00) O_WD_WARN <= 1'b1;
				if (wd_cnt_q == 8'h01) O_WD_RESET <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Dialling: wait for carrier up to two minutes of ticks
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			dial_act_q <= 1'b0;
			dcd_q <= 12'h0;
		end else if (I_ERR_EVENT && dial_len_q != 5'd0) begin
			dial_act_q <= 1'b1;
			dcd_q <= 12'h0;
		end else if (dial_act_q) begin
			if (dcd_s2_q) begin
				dial_act_q <= 1'b0;
			end else if (tick) begin
				dcd_q <= dcd_q + 12'h1;
				if (dcd_q == 12'(`SMHC_DCD_TICKS - 1)) dial_act_q <= 1'b0;
			end
		end
	end
	assign O_DIAL_ACTIVE = dial_act_q;

	//////////////////////////////////////////////////////////////////////////
	// Reply FIFO: input valid tied low, so nothing is queued and the data port reads zero
	assign out_data = 8'h00;
	smhc_fifo #(.WIDTH(8), .DEPTH(8)) u_reply (
		.i_clk(I_REF_CLK),
		.i_rst_b(I_RST_B),
		.i_in_valid(1'b0),
		.o_in_ready(),
		.i_in_data(8'h00),
		.o_out_valid(out_valid),
		.i_out_ready(out_pop),
		.o_out_data()
	);

	//////////////////////////////////////////////////////////////////////////
	// Checks
	chk_status_idle: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(st_q == SMHC_IDLE) |-> O_IO_RDATA[`SMHC_ST_CBE] || I_IO_ADDR != `SMHC_OFF_CMD) else $error("cbe wrong");
	chk_irq_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(st_q != SMHC_IDLE) |-> !O_IRQ_GO) else $error("irq during command");
	chk_data_drop: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(din_full_q && wr_dat) |=> $stable(din_q) || !din_full_q) else $error("data overwritten");
	chk_echo_rst: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		$rose(I_RST_B) |-> !echo_q && verbose_q) else $error("bad reset setting");
	chk_data_tmo: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(st_q == SMHC_DATA && !din_full_q && tmo_q == 32'(`SMHC_TIMEOUT_CYC - 1)) |=> st_q == SMHC_IDLE)
		else $error("command not dropped on timeout");
	chk_wd_pulse: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
		O_WD_RESET |=> !O_WD_RESET) else $error("watchdog reset pulse too long");
endmodule // smhc_port

// >>> smhc_params.svh
/*
 * Constants for the host command port of the system monitor: port offsets,
 * status bit positions, command codes, reset values and timing counts.
 * Assumes a 25 MHz reference clock; included by bare name.
 */
`ifndef SMHC_PARAMS_SVH
`define SMHC_PARAMS_SVH
`define SMHC_OFF_DATA 12'h132
`define SMHC_OFF_CMD 12'h133
`define SMHC_ST_CBE 0
`define SMHC_ST_IBE 1
`define SMHC_ST_OBF 2
`define SMHC_ST_NIRQ 7
`define SMHC_CMD_PASSWORD 8'h05
`define SMHC_CMD_DIAL 8'h06
`define SMHC_CMD_UNITID 8'h07
`define SMHC_CMD_ECHO 8'h08
`define SMHC_CMD_VERBOSE 8'h09
`define SMHC_CMD_WDEN 8'h0a
`define SMHC_CMD_WDWARN 8'h0b
`define SMHC_CMD_STROBE 8'h0c
`define SMHC_STR_END 8'h2a
`define SMHC_DIAL_MAX 20
`define SMHC_UNIT_MAX 10
`define SMHC_PW_LEN 3
`define SMHC_RST_ECHO 1'b0
`define SMHC_RST_VERBOSE 1'b1
`define SMHC_CLK_HZ 25000000
`define SMHC_BAUD 9600
`define SMHC_BIT_CYC (`SMHC_CLK_HZ / `SMHC_BAUD)
`define SMHC_TIMEOUT_MS 2000
`define SMHC_TIMEOUT_CYC (`SMHC_TIMEOUT_MS * (`SMHC_CLK_HZ / 1000))
`define SMHC_TICK_MS 50
`define SMHC_TICK_CYC (`SMHC_TICK_MS * (`SMHC_CLK_HZ / 1000))
`define SMHC_DCD_S 120
`define SMHC_DCD_TICKS (`SMHC_DCD_S * 1000 / `SMHC_TICK_MS)
`define SMHC_CH_AT 8'h40
`define SMHC_CH_COLON 8'h3a
`define SMHC_CH_CR 8'h0d
`endif

// >>> smhc_pkg.sv
/*
 * Types for the host command port of the system monitor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package smhc_pkg;
	typedef enum logic [1:0] {
		SMHC_IDLE = 2'b00,
		SMHC_DATA = 2'b01,
		SMHC_EXEC = 2'b10
	} smhc_cmd_state_t;
	typedef enum logic [1:0] {
		SMHC_SP_WAIT = 2'b00,
		SMHC_SP_HI = 2'b01,
		SMHC_SP_LO = 2'b10,
		SMHC_SP_SEP = 2'b11
	} smhc_ser_state_t;
endpackage

// >>> smhc_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module smhc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count
	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rd_q];

	// Storage has no reset; only the pointers and count need one
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // smhc_fifo

// >>> smhc_host_model.sv
/*
 * Behavioural host processor for the monitor's command port: polled status
 * reads, command and data writes, checked reads handed to the bench.
 * Assumes the port samples strobes on the rising clock edge and answers reads
 * combinationally while the strobe is held.
 */
`timescale 1ns/1ps
`include "smhc_params.svh"
module smhc_host_model (
	input wire logic i_clk,
	input wire logic [1:0] i_gap,
	input wire logic i_rude,
	input wire logic [7:0] i_rdata,
	output logic [11:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_wdata,
	output logic o_got,
	output logic [7:0] o_got_byte
);
	//////////////////////////////////////////////////////////////////////////////
	// Bus idle at time zero
	initial begin
		o_addr = 12'h000;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 8'h00;
		o_got = 1'b0;
		o_got_byte = 8'h00;
	end

	//////////////////////////////////////////////////////////////////////////////
	// One strobed access; the random gap makes the host prompt or slow.
	// Released lines show inverted values so stale data is never mistaken.
	task automatic cycle(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] v);
		repeat (i_gap) @(posedge i_clk);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= w;
		o_rd <= !w;
		@(posedge i_clk);
		v = i_rdata;
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	// Poll status until the chosen flag is set, bounded so a dead port cannot hang us
	task automatic poll(input int bit_n, input logic also_irq);
		logic [7:0] s;
		for (int n = 0; n < 200; n++) begin
			cycle(1'b0, `SMHC_OFF_CMD, 8'h00, s);
			if (s[bit_n] === 1'b1 && (!also_irq || s[`SMHC_ST_NIRQ] === 1'b1)) break;
		end
	endtask

	// Command write; a rude host skips the pending-interrupt check
	task automatic cmd(input logic [7:0] c);
		logic [7:0] s;
		poll(`SMHC_ST_CBE, !i_rude);
		cycle(1'b1, `SMHC_OFF_CMD, c, s);
	endtask

	// Data write only once the data input buffer is empty
	task automatic dat(input logic [7:0] d);
		logic [7:0] s;
		poll(`SMHC_ST_IBE, 1'b0);
		cycle(1'b1, `SMHC_OFF_DATA, d, s);
	endtask

	// Two data writes on consecutive edges; the second breaks the empty-flag wait
	task automatic wr2(input logic [7:0] d0, input logic [7:0] d1);
		poll(`SMHC_ST_IBE, 1'b0);
		@(posedge i_clk);
		o_addr <= `SMHC_OFF_DATA;
		o_wdata <= d0;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wdata <= d1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d1;
	endtask

	// Read whose byte goes to the bench's checker for one cycle
	task automatic rd_chk(input logic [11:0] a);
		logic [7:0] v;
		if (a == `SMHC_OFF_DATA) poll(`SMHC_ST_OBF, 1'b0);
		cycle(1'b0, a, 8'h00, v);
		o_got_byte <= v;
		o_got <= 1'b1;
		@(posedge i_clk);
		o_got <= 1'b0;
	endtask
endmodule // smhc_host_model

// >>> smhc_port_test.sv
/*
 * Self-checking bench for the monitor's host command port: status flags,
 * handshake, settings commands, refused writes, string lengths, dialling.
 * Assumes the host model above; serial lines idle, modem carrier absent until the last step.
 */
`timescale 1ns/1ps
`include "smhc_params.svh"
module smhc_port_test;
	logic clk, rst_b, irq_req, err_event, rude, snap, got, ser_rxd, cts_b, dcd;
	logic [11:0] addr;
	logic wr, rd;
	logic [7:0] wdata, rdata, got_byte, exp_b, obs_b;
	logic [7:0] lfsr = 8'h52;
	logic echo_e, verb_e, txd, rts_b, go, echo, verb, lock, warn, wd_rst, dial;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	//////////////////////////////////////////////////////////////////////////////
	// Clock, reset and stimulus start values
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		irq_req = 1'b0;
		err_event = 1'b0;
		rude = 1'b0;
		snap = 1'b0;
		ser_rxd = 1'b1;
		cts_b = 1'b0;
		dcd = 1'b0;
	end

	smhc_port i_dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_IO_ADDR(addr), .I_IO_WR(wr), .I_IO_RD(rd),
		.I_IO_WDATA(wdata), .O_IO_RDATA(rdata), .I_IRQ_REQ(irq_req), .O_IRQ_GO(go), .I_SER_RXD(ser_rxd),
		.O_SER_TXD(txd), .I_SER_CTS_B(cts_b), .O_SER_RTS_B(rts_b), .I_SER_DCD(dcd), .I_ERR_EVENT(err_event),
		.O_DIAL_ACTIVE(dial), .O_ECHO_EN(echo), .O_VERBOSE(verb), .O_PW_LOCKED(lock), .O_WD_WARN(warn),
		.O_WD_RESET(wd_rst));
	smhc_host_model i_host (.i_clk(clk), .i_gap(lfsr[1:0]), .i_rude(rude), .i_rdata(rdata), .o_addr(addr),
		.o_wr(wr), .o_rd(rd), .o_wdata(wdata), .o_got(got), .o_got_byte(got_byte));

	//////////////////////////////////////////////////////////////////////////////
	// Pseudo-random bytes; they set the host's pacing and the string contents
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	always @(posedge clk) begin
		lfsr <= lfsr_next(lfsr);
	end
	// Never hand out the string terminator by accident
	function automatic logic [7:0] rb();
		return (lfsr == `SMHC_STR_END) ? 8'h2b : lfsr;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Checker: oldest expectation against each read byte or level snapshot
	always @(posedge clk) begin
		if (got || snap) begin
			exp_b = exp_q.pop_front();
			obs_b = got ? got_byte : {echo, verb, lock, go, dial, warn, wd_rst, 1'b0};
			n_checks++;
			if (obs_b !== exp_b) begin
				num_errors++;
				$display("[ERR] t=%0t exp=%h got=%h", $time, exp_b, obs_b);
			end
		end
	end

	// Hang guard well above the few thousand cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Bench tasks
	task automatic test_done();
		if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rd_exp(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.rd_chk(a);
	endtask
	// Snapshot of echo, verbose, lock, go and dial; watchdog outputs must stay low
	task automatic lv(input logic e, input logic v, input logic l, input logic g, input logic d);
		exp_q.push_back({e, v, l, g, d, 3'b000});
		@(posedge clk);
		snap <= 1'b1;
		@(posedge clk);
		snap <= 1'b0;
	endtask
	task automatic idle();
		i_host.poll(`SMHC_ST_CBE, 1'b0);
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		static logic [7:0] tc [4] = '{8'h08, 8'h09, 8'h08, 8'h09};
		static logic [7:0] tv [4] = '{8'h01, 8'h00, 8'h00, 8'h01};
		echo_e = `SMHC_RST_ECHO;
		verb_e = `SMHC_RST_VERBOSE;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		// Reset status and settings, unmapped address reads zero
		rd_exp(`SMHC_OFF_CMD, 8'h83);
		rd_exp(12'h134, 8'h00);
		rd_exp(`SMHC_OFF_DATA, 8'h00);
		lv(echo_e, verb_e, 1'b0, 1'b0, 1'b0);
		// Echo and verbose both ways; status while the data byte is awaited
		for (int i = 0; i < 4; i++) begin
			i_host.cmd(tc[i]);
			rd_exp(`SMHC_OFF_CMD, 8'h82);
			i_host.dat(tv[i]);
			idle();
			if (tc[i] == `SMHC_CMD_ECHO) echo_e = tv[i][0];
			else verb_e = tv[i][0];
			lv(echo_e, verb_e, 1'b0, 1'b0, 1'b0);
		end
		// Interrupt delivery held off while a command is in progress
		irq_req <= 1'b1;
		rude <= 1'b1;
		rd_exp(`SMHC_OFF_CMD, 8'h03);
		lv(echo_e, verb_e, 1'b0, 1'b1, 1'b0);
		i_host.cmd(`SMHC_CMD_VERBOSE);
		lv(echo_e, verb_e, 1'b0, 1'b0, 1'b0);
		rd_exp(`SMHC_OFF_CMD, 8'h02);
		i_host.dat(8'h01);
		idle();
		lv(echo_e, 1'b1, 1'b0, 1'b1, 1'b0);
		irq_req <= 1'b0;
		rude <= 1'b0;
		// Nonzero password locks; a too-early data write is dropped
		i_host.cmd(`SMHC_CMD_PASSWORD);
		for (int i = 0; i < `SMHC_PW_LEN; i++) i_host.dat(lfsr | 8'h01);
		idle();
		lv(echo_e, 1'b1, 1'b1, 1'b0, 1'b0);
		i_host.cmd(`SMHC_CMD_PASSWORD);
		i_host.wr2(8'h00, 8'h55);
		i_host.dat(8'h00);
		i_host.dat(8'h00);
		idle();
		lv(echo_e, 1'b1, 1'b0, 1'b0, 1'b0);
		// Full-length strings end the command without a terminator
		i_host.cmd(`SMHC_CMD_UNITID);
		for (int i = 0; i < `SMHC_UNIT_MAX; i++) i_host.dat(rb());
		repeat (2) @(posedge clk);
		rd_exp(`SMHC_OFF_CMD, 8'h83);
		i_host.cmd(`SMHC_CMD_DIAL);
		for (int i = 0; i < `SMHC_DIAL_MAX; i++) i_host.dat(rb());
		repeat (2) @(posedge clk);
		rd_exp(`SMHC_OFF_CMD, 8'h83);
		// Short dial string ended by the terminator byte
		i_host.cmd(`SMHC_CMD_DIAL);
		i_host.dat(rb());
		i_host.dat(rb());
		i_host.dat(`SMHC_STR_END);
		repeat (2) @(posedge clk);
		rd_exp(`SMHC_OFF_CMD, 8'h83);
		// Watchdog enable, warning point, strobe without data, then disable
		i_host.cmd(`SMHC_CMD_WDEN);
		i_host.dat(8'hff);
		i_host.cmd(`SMHC_CMD_WDWARN);
		i_host.dat(lfsr);
		i_host.cmd(`SMHC_CMD_STROBE);
		rd_exp(`SMHC_OFF_CMD, 8'h83);
		i_host.cmd(`SMHC_CMD_WDEN);
		i_host.dat(8'h00);
		idle();
		lv(echo_e, 1'b1, 1'b0, 1'b0, 1'b0);
		// An error event starts dialling when a dial string is stored
		@(posedge clk);
		err_event <= 1'b1;
		@(posedge clk);
		err_event <= 1'b0;
		repeat (4) @(posedge clk);
		lv(echo_e, 1'b1, 1'b0, 1'b0, 1'b1);
		// Carrier arriving ends the dialling wait
		dcd <= 1'b1;
		repeat (4) @(posedge clk);
		lv(echo_e, 1'b1, 1'b0, 1'b0, 1'b0);
		test_done();
	end
endmodule // smhc_port_test
